// >>> src/counter_state_store.sv
// 46-bit signed counter with error flag, kept as six encoded state bytes
// assumes commands arrive as one-cycle pulses, already framed by the serial front end
// Overview of operation
// - keep a 46-bit counter and a 2-bit error flag in the array
// - counter bits packed little-endian into bytes 0 to 4, eight per byte
// - byte 5 holds counter bits 45..40 low, flag in bits 7 and 6
// - count only while flag is 00; any other value stops counting
// - overflow or underflow sets flag 01 and halts counting
// - uncorrectable check error sets flag 10
// - an unfinished previous operation sets flag 11 and stops counting
// - incrementing 1FFF_FFFF_FFFF is overflow; flag 01, next count refused
// - decrementing 2000_0000_0000 is underflow; flag 01, counting stops
// - counter is two's complement; 3FFF_FFFF_FFFF means minus one
// - bytes are stored encoded; state writes may overwrite them
// - state write bytes go from address 0 upward, wrapping, until frame ends
module counter_state_store
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// counting commands, one-cycle pulses
	input  wire logic        direct_increment_cmd,
	input  wire logic        direct_decrement_cmd,
	// state write stream
	input  wire logic        state_write_start,
	input  wire logic        state_write_valid,
	input  wire logic [7:0]  state_write_data,
	// check fault injection
	input  wire logic        ecc_fault,
	// logical state for state reads, raw encoded image for plain reads
	output logic [45:0]      count_value,
	output logic [1:0]       error_flag,
	output logic             busy,
	output logic             cmd_refused,
	output logic [47:0]      stored_image
);
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_MARK  = 2'b01,
		ST_BYTES = 2'b11,
		ST_DONE  = 2'b10
	} state_e;

	state_e      st_q, st_d;
	logic [45:0] cnt_q, cnt_d;
	logic [45:0] new_q, new_d;
	logic [1:0]  flag_q, flag_d;
	logic [1:0]  fin_q, fin_d;
	logic [2:0]  idx_q, idx_d;
	logic [2:0]  waddr_q, waddr_d;
	logic        ref_q, ref_d;
	logic [47:0] img;
	state_mem_if mem ();
	// next values of the output flops
	logic [45:0] count_d;
	logic [1:0]  eflag_d;
	logic        busy_d;
	logic [47:0] image_d;

	function automatic logic [7:0] enc(input logic [7:0] b, input logic [2:0] a);
		enc = b ^ counter_store_pkg::ENC_KEY ^ {5'h0, a};
	endfunction

	// byte a of the logical layout
	function automatic logic [7:0] pick(input logic [45:0] c, input logic [1:0] f,
		input logic [2:0] a);
		logic [47:0] word;
		word = {f, c};
		pick = word[a*8 +: 8];
	endfunction

	function automatic logic [2:0] next_addr(input logic [2:0] a);
		next_addr = (a == counter_store_pkg::ADDR_LAST) ? counter_store_pkg::ADDR_FIRST
			: a + 3'h1;
	endfunction

	state_bytes u_bytes
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.port    (mem.mem),
		.corrupt (ecc_fault),
		.image   (img)
	);

	always_comb
	begin
		logic go;
		logic [47:0] w;
		go = 1'b0;
		w = 48'h0;
		st_d = st_q;
		cnt_d = cnt_q;
		new_d = new_q;
		flag_d = flag_q;
		fin_d = fin_q;
		idx_d = idx_q;
		waddr_d = waddr_q;
		ref_d = 1'b0;
		mem.we = 1'b0;
		mem.addr = 3'h0;
		mem.wdata = 8'h0;
		// only checked while idle, so an update never sees its own half-written bytes
		if (mem.ecc_bad && flag_q == counter_store_pkg::FLAG_OK && st_q == ST_IDLE)
			flag_d = counter_store_pkg::FLAG_ECC;
		case (st_q)
			ST_IDLE:
			begin
				go = direct_increment_cmd | direct_decrement_cmd;
				if (state_write_start)
					waddr_d = counter_store_pkg::ADDR_FIRST;
				else if (state_write_valid)
				begin
					// raw bytes overwrite the store; logical copy follows them
					mem.we = 1'b1;
					mem.addr = waddr_q;
					mem.wdata = enc(state_write_data, waddr_q);
					w = {flag_q, cnt_q};
					w[waddr_q*8 +: 8] = state_write_data;
					{flag_d, cnt_d} = w;
					waddr_d = next_addr(waddr_q);
				end
				// a check error found this cycle wins over the count
				else if (go && flag_d != counter_store_pkg::FLAG_OK)
					ref_d = 1'b1;
				else if (go)
				begin
					// the range test compares the old count with CNT_MAX or CNT_MIN
					new_d = direct_increment_cmd ? cnt_q + 46'h1 : cnt_q - 46'h1;
					if ((direct_increment_cmd && cnt_q == counter_store_pkg::CNT_MAX) ||
						(direct_decrement_cmd && cnt_q == counter_store_pkg::CNT_MIN))
						fin_d = counter_store_pkg::FLAG_RANGE;
					else
						fin_d = counter_store_pkg::FLAG_OK;
					flag_d = counter_store_pkg::FLAG_BUSY;
					st_d = ST_MARK;
				end
			end
			ST_MARK:
			begin
				// mark first so a cut-off update leaves flag 11 behind
				mem.we = 1'b1;
				mem.addr = counter_store_pkg::ADDR_LAST;
				mem.wdata = enc(pick(cnt_q, counter_store_pkg::FLAG_BUSY, 3'h5), 3'h5);
				idx_d = counter_store_pkg::ADDR_FIRST;
				st_d = ST_BYTES;
			end
			ST_BYTES:
			begin
				// byte 5 is rewritten with flag 11 too; only the closing write clears it
				mem.we = 1'b1;
				mem.addr = idx_q;
				mem.wdata = enc(pick(new_q, counter_store_pkg::FLAG_BUSY, idx_q), idx_q);
				idx_d = idx_q + 3'h1;
				if (idx_q == counter_store_pkg::ADDR_LAST)
				begin
					cnt_d = new_q;
					st_d = ST_DONE;
				end
			end
			ST_DONE:
			begin
				// the closing write drops the busy mark and sets the final flag
				mem.we = 1'b1;
				mem.addr = counter_store_pkg::ADDR_LAST;
				mem.wdata = enc(pick(cnt_q, fin_q, 3'h5), 3'h5);
				flag_d = fin_q;
				st_d = ST_IDLE;
			end
			default:
				st_d = ST_IDLE;
		endcase
	end

	// state reads see this logical copy; the image serves plain reads only
	always_comb
	begin
		count_d = cnt_d;
		eflag_d = flag_d;
		busy_d = (st_d != ST_IDLE);
		image_d = img;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_q <= ST_IDLE;
			cnt_q <= counter_store_pkg::CNT_RESET;
			new_q <= counter_store_pkg::CNT_RESET;
			flag_q <= counter_store_pkg::FLAG_OK;
			fin_q <= counter_store_pkg::FLAG_OK;
			idx_q <= 3'h0;
			waddr_q <= 3'h0;
			ref_q <= 1'b0;
			count_value <= counter_store_pkg::CNT_RESET;
			error_flag <= counter_store_pkg::FLAG_OK;
			busy <= 1'b0;
			stored_image <= 48'h0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			new_q <= new_d;
			flag_q <= flag_d;
			fin_q <= fin_d;
			idx_q <= idx_d;
			waddr_q <= waddr_d;
			ref_q <= ref_d;
			count_value <= count_d;
			error_flag <= eflag_d;
			busy <= busy_d;
			stored_image <= image_d;
		end
	end

	assign cmd_refused = ref_q;
endmodule

// >>> src/counter_store_pkg.sv
// constants for the 46-bit counter state store
// assumes a single 200 MHz clock domain, synchronous active-low reset
package counter_store_pkg;
	localparam int          CNT_W        = 46;
	localparam int          FLAG_W       = 2;
	localparam int          STATE_BYTES  = 6;
	localparam int          ADDR_W       = 3;
	localparam logic [2:0]  ADDR_FIRST   = 3'h0;
	localparam logic [2:0]  ADDR_LAST    = 3'h5;
	localparam int          FLAG_LSB     = 6;
	localparam int          TOP_CNT_BITS = 6;
	localparam logic [1:0]  FLAG_OK      = 2'h0;
	localparam logic [1:0]  FLAG_RANGE   = 2'h1;
	localparam logic [1:0]  FLAG_ECC     = 2'h2;
	localparam logic [1:0]  FLAG_BUSY    = 2'h3;
	localparam logic [45:0] CNT_MAX      = 46'h1FFF_FFFF_FFFF;
	localparam logic [45:0] CNT_MIN      = 46'h2000_0000_0000;
	localparam logic [45:0] CNT_RESET    = 46'h0000_0000_0000;
	localparam logic [7:0]  ENC_KEY      = 8'hA5;
endpackage

// >>> src/state_mem_if.sv
// carries the write port of the encoded state bytes
// assumes the store owns the array and the controller drives it
interface state_mem_if;
	logic       we;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic       ecc_bad;
	modport ctrl (output we, addr, wdata, input ecc_bad);
	modport mem  (input we, addr, wdata, output ecc_bad);
endinterface

// >>> src/state_bytes.sv
// six encoded state bytes held in flip-flops with a parity check bit each
// assumes writes come one byte per cycle from the controller
module state_bytes
(
	// clock and reset
	input  wire logic   clk,
	input  wire logic   rst_n,
	// write port and check result
	state_mem_if.mem    port,
	// fault injection for the check path
	input  wire logic   corrupt,
	// raw encoded image
	output logic [47:0] image
);
	logic [7:0] mem_q [6];
	logic [7:0] mem_d [6];
	logic [5:0] par_q;
	logic [5:0] par_d;
	logic       bad;

	always_comb
	begin
		mem_d = mem_q;
		par_d = par_q;
		if (port.we)
		begin
			mem_d[port.addr] = port.wdata;
			par_d[port.addr] = ^port.wdata ^ corrupt;
		end
		bad = 1'b0;
		for (int i = 0; i < 6; i++)
			bad = bad | (par_q[i] != ^mem_q[i]);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 6; i++)
				mem_q[i] <= counter_store_pkg::ENC_KEY;
			par_q <= 6'h0;
		end
		else
		begin
			mem_q <= mem_d;
			par_q <= par_d;
		end
	end

	assign port.ecc_bad = bad;
	assign image = {mem_q[5], mem_q[4], mem_q[3], mem_q[2], mem_q[1], mem_q[0]};
endmodule

// >>> sim/counter_state_store_sva.sv
// port assertions for the counter state store
// assumes a bind from the bench top, one clock
module counter_state_store_sva
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// requests
	input wire logic        direct_increment_cmd,
	input wire logic        direct_decrement_cmd,
	input wire logic        state_write_start,
	input wire logic        state_write_valid,
	// state
	input wire logic [45:0] count_value,
	input wire logic [1:0]  error_flag,
	input wire logic        busy,
	input wire logic        cmd_refused
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic req;
	logic take;
	logic up;
	// writes take priority, so a request beside a byte is not a count
	assign req = (direct_increment_cmd | direct_decrement_cmd) & !busy
		& !state_write_start & !state_write_valid;
	assign take = req & (error_flag == 2'h0);
	assign up = direct_increment_cmd;
	a_take_mark: assert property (take |=> busy && error_flag == 2'h3)
		else $error("no mark");
	a_busy_mark: assert property (busy |-> error_flag == 2'h3)
		else $error("flag off while busy");
	a_done_nine: assert property (take |-> ##9 !busy && error_flag != 2'h3)
		else $error("late finish");
	a_inc_step: assert property (take && up && count_value != 46'h1FFF_FFFF_FFFF
		|-> ##8 count_value == $past(count_value, 8) + 46'h1)
		else $error("bad increment");
	a_dec_step: assert property (take && !up && count_value != 46'h2000_0000_0000
		|-> ##8 count_value == $past(count_value, 8) - 46'h1)
		else $error("bad decrement");
	a_over_flag: assert property (take && up && count_value == 46'h1FFF_FFFF_FFFF
		|-> ##9 error_flag == 2'h1 && count_value == 46'h2000_0000_0000)
		else $error("no overflow");
	a_under_flag: assert property (take && !up && count_value == 46'h2000_0000_0000
		|-> ##9 error_flag == 2'h1 && count_value == 46'h1FFF_FFFF_FFFF)
		else $error("no underflow");
	a_flag_halt: assert property (req && error_flag != 2'h0
		|=> cmd_refused && $stable(count_value))
		else $error("count not halted");
endmodule

// >>> sim/state_write_host.sv
// host model sending state write frames
// assumes calls are made at a falling clock edge
module state_write_host
(
	// clock
	input wire logic   clk,
	// write stream
	output logic       start,
	output logic       valid,
	output logic [7:0] data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		start = 1'b0;
		valid = 1'b0;
		data = 8'h00;
	end
	// bytes go from address 0 upward, wrapping past the top
	task automatic send(input logic [47:0] v, input int n);
		@(negedge clk) start = 1'b1;
		@(negedge clk) start = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			valid = 1'b1;
			data = v[8 * (i % 6) +: 8];
			@(negedge clk);
		end
		valid = 1'b0;
		// released bus must not show the last byte
		data = ~data;
	endtask
endmodule

// >>> sim/counter_state_store_tb.sv
// bench for the counter state store: frames, counts, refusals, check fault
// assumes the host model drives the state write stream
module counter_state_store_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        inc = 1'b0;
	logic        dec = 1'b0;
	logic        fault = 1'b0;
	logic        start, valid, busy, refused;
	logic [7:0]  data;
	logic [45:0] cnt;
	logic [1:0]  flag;
	logic [47:0] img, s, e;
	logic [47:0] tv [6];
	logic [1:0]  td [6];
	logic [1:0]  d;
	logic [15:0] r;
	int          err_count = 0;
	int          checks = 0;
	int          cyc = 0;
	always #2.5 clk = ~clk;
	counter_state_store dut
	(
		.clk(clk), .rst_n(rst_n), .direct_increment_cmd(inc), .direct_decrement_cmd(dec),
		.state_write_start(start), .state_write_valid(valid), .state_write_data(data),
		.ecc_fault(fault), .count_value(cnt), .error_flag(flag), .busy(busy),
		.cmd_refused(refused), .stored_image(img)
	);
	state_write_host host (.clk(clk), .start(start), .valid(valid), .data(data));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [47:0] enc(input logic [47:0] x);
		for (int a = 0; a < 6; a++)
			x[8 * a +: 8] ^= counter_store_pkg::ENC_KEY ^ 8'(a);
		return x;
	endfunction
	function automatic logic [47:0] next_state(input logic [47:0] x, input logic [1:0] k);
		if (x[47:46] != 2'h0)
			return x;
		if (k[0])
			return {(x[45:0] == 46'h1FFF_FFFF_FFFF) ? 2'h1 : 2'h0, x[45:0] + 46'h1};
		return {(x[45:0] == 46'h2000_0000_0000) ? 2'h1 : 2'h0, x[45:0] - 46'h1};
	endfunction
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	// both high for k 3: increment must win
	task automatic pulse(input logic [1:0] k);
		inc = k[0];
		dec = k[1] | ~k[0];
		@(negedge clk);
		inc = 1'b0;
		dec = 1'b0;
	endtask
	task automatic close_out();
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_count++;
			close_out();
		end
	end
	initial
	begin
		tv = '{48'h1FFF_FFFF_FFFF, 48'h2000_0000_0000, 48'h3FFF_FFFF_FFFF, 48'h0,
			48'hC000_0000_0005, 48'h8000_0000_0005};
		td = '{2'h1, 2'h0, 2'h3, 2'h0, 2'h1, 2'h0};
		r = 16'h3251;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk(cnt === 46'h0 && flag === 2'h0 && busy === 1'b0, "reset");
		for (int i = 0; i < 12; i++)
		begin
			r = lfsr(r);
			s = (i < 6) ? tv[i] : {2'h0, r[13:0], lfsr(r), lfsr(lfsr(r))};
			d = (i < 6) ? td[i] : {1'b0, r[5]};
			e = next_state(s, d);
			host.send(s, 6);
			repeat (2) @(negedge clk);
			chk({flag, cnt} === s, "state write");
			chk(img === enc(s), "image");
			pulse(d);
			if (s[47:46] != 2'h0)
				chk(refused === 1'b1, "refuse");
			else
				chk(busy === 1'b1 && flag === 2'h3, "mark");
			repeat (8) @(negedge clk);
			chk({flag, cnt} === e && busy === 1'b0, "count");
			// the image flop trails the closing byte write by one cycle
			@(negedge clk);
			chk(img === enc(e), "write back");
			pulse(2'h1);
			chk(refused === (e[47:46] != 2'h0), "halt");
			repeat (9) @(negedge clk);
		end
		fault = 1'b1;
		host.send(48'h0, 6);
		fault = 1'b0;
		for (int k = 0; k < 20 && flag !== 2'h2; k++)
			@(negedge clk);
		chk(flag === 2'h2, "check fault");
		pulse(2'h1);
		chk(refused === 1'b1, "fault halt");
		close_out();
	end
endmodule
bind counter_state_store counter_state_store_sva sva
(
	.clk(clk), .rst_n(rst_n), .direct_increment_cmd(direct_increment_cmd),
	.direct_decrement_cmd(direct_decrement_cmd), .state_write_start(state_write_start),
	.state_write_valid(state_write_valid), .count_value(count_value),
	.error_flag(error_flag), .busy(busy), .cmd_refused(cmd_refused)
);
